// ==== rtl/tcfc_defines.vh ====
`ifndef TCFC_DEFINES_VH
`define TCFC_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TCFC_OFF_FUNC 8'h00
`define TCFC_OFF_SEQ 8'h04
`define TCFC_OFF_REQ 8'h08
`define TCFC_OFF_CTRL 8'h0C
`define TCFC_OFF_MATCH 8'h10
`define TCFC_OFF_CAPTURE 8'h14
`define TCFC_OFF_STATUS 8'h18
`define TCFC_OFF_MASK 8'h1C
`define TCFC_OFF_DECODED 8'h20
`define TCFC_OFF_TIMEBASE 8'h24
`define TCFC_OFF_CONFIG 8'h28

// ----------------------------------------
// Function codes
// ----------------------------------------
`define TCFC_FN_TIME_ACCUM 4'hF
`define TCFC_FN_QUEUED_MATCH 4'hE
`define TCFC_FN_TABLE_STEPPER 4'hD
`define TCFC_FN_FREQ_MEASURE 4'hC
`define TCFC_FN_SERIAL 4'hB
`define TCFC_FN_TRANS_COUNT 4'hA
`define TCFC_FN_COMMUTATION 4'h9
`define TCFC_FN_HALL_DECODE 4'h8
`define TCFC_FN_MULTI_PWM 4'h7
`define TCFC_FN_FAST_QUAD 4'h6

// ----------------------------------------
// Decoded actions and initial pin levels
// ----------------------------------------
`define TCFC_ACT_NONE 3'h0
`define TCFC_ACT_INIT 3'h1
`define TCFC_ACT_MOVE 3'h2
`define TCFC_ACT_RECV 3'h3
`define TCFC_ACT_XMIT 3'h4
`define TCFC_ACT_FORCE 3'h5
`define TCFC_ACT_TEST 3'h6
`define TCFC_ACT_READTB 3'h7
`define TCFC_INIT_KEEP 2'h0
`define TCFC_INIT_LOW 2'h1
`define TCFC_INIT_HIGH 2'h2

// ----------------------------------------
// Channel control fields and codes
// ----------------------------------------
`define TCFC_CTRL_TBS_KEEP 8
`define TCFC_CTRL_PAF_KEEP 4
`define TCFC_PAF_NONE 2'h0
`define TCFC_PAF_RISE 2'h1
`define TCFC_PAF_FALL 2'h2
`define TCFC_PAF_BOTH 2'h3
`define TCFC_PSF_LATCH 2'h0
`define TCFC_PSF_HIGH 2'h1
`define TCFC_PSF_LOW 2'h2

// ----------------------------------------
// Status bits, bus responses, timing
// ----------------------------------------
`define TCFC_ST_TRANS 0
`define TCFC_ST_MATCH 1
`define TCFC_ST_DONE 2
`define TCFC_ST_IGNORED 3
`define TCFC_TB2_DIV 8'h04
`define TCFC_RESP_OKAY 2'h0
`define TCFC_RESP_SLVERR 2'h2

`endif

// ==== rtl/tcfc_request_decode.v ====
`include "tcfc_defines.vh"
`default_nettype none

module tcfc_request_decode (
	input wire [3:0] funcCode,
	input wire [1:0] seqCode,
	input wire [1:0] reqCode,
	input wire stepMaster,
	output reg accepted,
	output reg [2:0] action,
	output reg [3:0] modeFlags,
	output reg [1:0] initPin
);

always @* begin
	accepted = 1'b0;
	action = `TCFC_ACT_NONE;
	modeFlags = 4'h0;
	initPin = `TCFC_INIT_KEEP;
	if (reqCode != 2'h0) begin // [R12]
		case (funcCode)
		`TCFC_FN_TIME_ACCUM: begin
			if (reqCode == 2'h3) begin // [R1]
				accepted = 1'b1;
				action = `TCFC_ACT_INIT;
				modeFlags = {2'h0, seqCode}; // [R1]
			end
		end
		`TCFC_FN_QUEUED_MATCH: begin
			accepted = 1'b1;
			action = `TCFC_ACT_INIT;
			initPin = reqCode - 2'h1; // [R2]
			modeFlags = {2'h0, (seqCode == 2'h3) ? 2'h2 : seqCode}; // [R2]
		end
		`TCFC_FN_TABLE_STEPPER: begin
			modeFlags = {2'h0, seqCode}; // [R4]
			if (reqCode != 2'h3) begin
				accepted = 1'b1;
				action = `TCFC_ACT_INIT;
				initPin = reqCode; // [R3]
			end else if (stepMaster) begin // [R3]
				accepted = 1'b1;
				action = `TCFC_ACT_MOVE;
			end
		end
		`TCFC_FN_FREQ_MEASURE: begin
			if (reqCode == 2'h2) begin // [R5]
				accepted = 1'b1;
				action = `TCFC_ACT_INIT;
				modeFlags = {2'h0, seqCode}; // [R5]
			end
		end
		`TCFC_FN_SERIAL: begin
			if (reqCode[1]) begin
				accepted = 1'b1;
				action = reqCode[0] ? `TCFC_ACT_XMIT : `TCFC_ACT_RECV; // [R6]
				modeFlags = {2'h0, seqCode[1] ? {seqCode[0], ~seqCode[0]} :
					2'h0}; // [R6]
			end
		end
		`TCFC_FN_TRANS_COUNT: begin
			if (reqCode != 2'h3) begin // [R7]
				accepted = 1'b1;
				action = `TCFC_ACT_INIT;
				modeFlags = {1'b0, reqCode[1], seqCode}; // [R7]
			end
		end
		`TCFC_FN_COMMUTATION: begin
			if (reqCode[1]) begin
				accepted = 1'b1;
				action = reqCode[0] ? `TCFC_ACT_TEST : `TCFC_ACT_FORCE; // [R8]
				modeFlags = {2'h0, seqCode[1] ? {seqCode[0], ~seqCode[0]} :
					2'h0}; // [R8]
			end
		end
		`TCFC_FN_HALL_DECODE: begin
			if (reqCode[1] && (reqCode[0] || seqCode != 2'h3)) begin // [R9]
				accepted = 1'b1;
				action = `TCFC_ACT_INIT;
				modeFlags = {1'b0, reqCode[0], (seqCode == 2'h3) ? 2'h2 :
					{1'b0, seqCode != 2'h0}}; // [R9]
			end
		end
		`TCFC_FN_MULTI_PWM: begin
			accepted = 1'b1;
			action = `TCFC_ACT_INIT;
			modeFlags = {reqCode - 2'h1, seqCode[1] ? 2'h2 :
				{1'b0, seqCode[0]}}; // [R10]
		end
		`TCFC_FN_FAST_QUAD: begin
			if (reqCode[1]) begin
				accepted = 1'b1;
				action = reqCode[0] ? `TCFC_ACT_INIT : `TCFC_ACT_READTB; // [R11]
				modeFlags = {2'h0, seqCode}; // [R11]
			end
		end
		default: begin
			accepted = 1'b0;
		end
		endcase
	end
end

endmodule // tcfc_request_decode

`default_nettype wire

// ==== rtl/tcfc_channel.v ====
// Summary of operation
// R1 - Time accumulate: init on request 3, sequence picks accumulate kind
// R2 - Queued match: requests 1-3 init keep/low/high; sequence shot/loop/cont
// R3 - Stepper: request 1 pin low, 2 pin high, 3 move if master
// R4 - Stepper sequence: bit1 rotate twice, bit0 split table
// R5 - Frequency measure: init on 2; bit1 rising start, bit0 continuous
// R6 - Serial: 2 receive, 3 transmit; sequence 2 even, 3 odd parity
// R7 - Transition count: 1 time-base init, 2 parameter init; bit0/bit1
// R8 - Commutation: 2 force state, 3 state test; sequence picks update mode
// R9 - Hall: 2 two-channel, 3 three-channel; sequence picks channel A/B/C
// R10 - Multichannel PWM: inverted slave, slave, master; alignment from seq
// R11 - Fast quadrature: 2 reads first time base, 3 inits; fast, secondary
// R12 - Request code zero never triggers any action
// R13 - Time base field sets direction and match, capture counters apart
// R14 - Input: pin action picks edge; edge sets transition latch
// R15 - Output: pin action picks level driven on match latch
// R16 - Pin action codes none/rise/fall/both; top bit set keeps field
// R17 - Pin state field forces high or low without touching latches
// R18 - Time base 00xx input, 01xx output; top bit set keeps field
// R19 - Host sets codes before a request, one request at a time
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`include "tcfc_defines.vh"
`default_nettype none

module tcfc_channel (
	input wire clk_sys,
	input wire resetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire pinIn,
	output wire pinOut,
	output wire pinOe,
	output wire irq
);

// ----------------------------------------
// State
// ----------------------------------------
reg awReady_reg, wReady_reg, awGot_reg, wGot_reg, bValid_reg;
reg arReady_reg, rValid_reg;
reg [7:0] awAddr_reg;
reg [31:0] wData_reg, rData_reg;
reg [3:0] wStrb_reg;
reg [1:0] bResp_reg, rResp_reg;

reg [3:0] funcCode_reg, status_reg, mask_reg;
reg [1:0] sequenceCode_reg, serviceRequestCode_reg;
reg [2:0] timeBaseSelect_reg;
reg [1:0] pinActionField_reg, pinStateForce_reg;
reg [15:0] matchValue_reg, capture_reg;
reg [9:0] decoded_reg;
reg [15:0] firstTimeBase_reg, secondTimeBase_reg;
reg [7:0] div_reg;
reg stepMaster_reg, pinSync1_reg, pinSync2_reg, pinPrev_reg;
reg matchEq_reg, pinLevel_reg, pinOut_reg, pinOe_reg, irq_reg;

// ----------------------------------------
// Combinational signals
// ----------------------------------------
wire decAccepted, doWrite, wrFunc, wrSeq, wrReq, wrCtrl, wrMatch;
wire wrStatus, wrMask, wrConfig, wrHit, isOutput, matchEq, matchEvent;
wire riseSeen, fallSeen, edgeSeen, serveNow;
wire [2:0] decAction;
wire [3:0] decFlags, events, status_next;
wire [1:0] decInitPin;
wire [31:0] wMask, wBits;
wire [8:0] ctrlNow, ctrlNew;
wire [15:0] matchBase, captureBase;
reg pinLevel_next, pinOut_next, readHit;
reg [31:0] readData;

// ----------------------------------------
// Request decoder
// ----------------------------------------
tcfc_request_decode requestDecode (
	.funcCode(funcCode_reg),
	.seqCode(sequenceCode_reg),
	.reqCode(serviceRequestCode_reg),
	.stepMaster(stepMaster_reg),
	.accepted(decAccepted),
	.action(decAction),
	.modeFlags(decFlags),
	.initPin(decInitPin)
);

// ----------------------------------------
// Write decode
// ----------------------------------------
assign wMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}},
	{8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
assign wBits = wData_reg & wMask;
assign doWrite = awGot_reg & wGot_reg & ~bValid_reg;
assign wrFunc = doWrite && (awAddr_reg == `TCFC_OFF_FUNC);
assign wrSeq = doWrite && (awAddr_reg == `TCFC_OFF_SEQ);
assign wrReq = doWrite && (awAddr_reg == `TCFC_OFF_REQ);
assign wrCtrl = doWrite && (awAddr_reg == `TCFC_OFF_CTRL);
assign wrMatch = doWrite && (awAddr_reg == `TCFC_OFF_MATCH);
assign wrStatus = doWrite && (awAddr_reg == `TCFC_OFF_STATUS);
assign wrMask = doWrite && (awAddr_reg == `TCFC_OFF_MASK);
assign wrConfig = doWrite && (awAddr_reg == `TCFC_OFF_CONFIG);
assign wrHit = wrFunc | wrSeq | wrReq | wrCtrl | wrMatch | wrStatus |
	wrMask | wrConfig | (awAddr_reg == `TCFC_OFF_CAPTURE) |
	(awAddr_reg == `TCFC_OFF_DECODED) |
	(awAddr_reg == `TCFC_OFF_TIMEBASE);

// Byte lanes merge first, then the keep bits are honoured
assign ctrlNow = {1'b0, timeBaseSelect_reg, 1'b0, pinActionField_reg,
	pinStateForce_reg};
assign ctrlNew = (ctrlNow & ~wMask[8:0]) | wBits[8:0];

// ----------------------------------------
// Channel events
// ----------------------------------------
assign isOutput = timeBaseSelect_reg[2]; // [R13]
assign matchBase = timeBaseSelect_reg[0] ? secondTimeBase_reg :
	firstTimeBase_reg; // [R13]
assign captureBase = timeBaseSelect_reg[1] ? secondTimeBase_reg :
	firstTimeBase_reg; // [R13]
// Slow base holds a value many cycles, so only the first equal cycle counts
assign matchEq = isOutput && (matchBase == matchValue_reg);
assign matchEvent = matchEq & ~matchEq_reg;
assign riseSeen = pinSync2_reg & ~pinPrev_reg;
assign fallSeen = ~pinSync2_reg & pinPrev_reg;
assign edgeSeen = ~isOutput && (
	(riseSeen && pinActionField_reg[0]) ||
	(fallSeen && pinActionField_reg[1])); // [R14] [R16]

// Host keeps one request in flight; a fresh write beats the service
assign serveNow = (serviceRequestCode_reg != 2'h0) && ~wrReq; // [R12] [R19]
assign events = {serveNow & ~decAccepted, serveNow & decAccepted,
	matchEvent, edgeSeen};
// Hardware set wins over a write-one clear in the same cycle
assign status_next = (status_reg & ~({4{wrStatus}} & wBits[3:0])) |
	events;

always @* begin
	pinLevel_next = pinLevel_reg;
	if (matchEvent) begin
		case (pinActionField_reg)
		`TCFC_PAF_RISE: pinLevel_next = 1'b1; // [R15] [R16]
		`TCFC_PAF_FALL: pinLevel_next = 1'b0; // [R15] [R16]
		`TCFC_PAF_BOTH: pinLevel_next = ~pinLevel_reg; // [R15] [R16]
		default: pinLevel_next = pinLevel_reg;
		endcase
	end
	if (serveNow && decAccepted) begin
		if (decInitPin == `TCFC_INIT_LOW) begin
			pinLevel_next = 1'b0;
		end else if (decInitPin == `TCFC_INIT_HIGH) begin
			pinLevel_next = 1'b1;
		end
	end
end

always @* begin
	case (pinStateForce_reg)
	`TCFC_PSF_HIGH: pinOut_next = 1'b1; // [R17]
	`TCFC_PSF_LOW: pinOut_next = 1'b0; // [R17]
	default: pinOut_next = pinLevel_next; // [R17]
	endcase
end

// ----------------------------------------
// Read mux
// ----------------------------------------
always @* begin
	readData = 32'h0;
	readHit = 1'b1;
	case (s_axi_araddr)
	`TCFC_OFF_FUNC: readData[3:0] = funcCode_reg;
	`TCFC_OFF_SEQ: readData[1:0] = sequenceCode_reg;
	`TCFC_OFF_REQ: readData[1:0] = serviceRequestCode_reg;
	`TCFC_OFF_CTRL: readData[8:0] = ctrlNow;
	`TCFC_OFF_MATCH: readData[15:0] = matchValue_reg;
	`TCFC_OFF_CAPTURE: readData[15:0] = capture_reg;
	`TCFC_OFF_STATUS: readData[3:0] = status_reg;
	`TCFC_OFF_MASK: readData[3:0] = mask_reg;
	`TCFC_OFF_DECODED: readData[9:0] = decoded_reg;
	`TCFC_OFF_TIMEBASE: readData = {secondTimeBase_reg, firstTimeBase_reg};
	`TCFC_OFF_CONFIG: readData[0] = stepMaster_reg;
	default: readHit = 1'b0;
	endcase
end

// ----------------------------------------
// Bus slave
// ----------------------------------------
always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		awReady_reg <= 1'b1;
		wReady_reg <= 1'b1;
		awGot_reg <= 1'b0;
		wGot_reg <= 1'b0;
		awAddr_reg <= 8'h00;
		wData_reg <= 32'h0;
		wStrb_reg <= 4'h0;
		bValid_reg <= 1'b0;
		bResp_reg <= `TCFC_RESP_OKAY;
		arReady_reg <= 1'b1;
		rValid_reg <= 1'b0;
		rData_reg <= 32'h0;
		rResp_reg <= `TCFC_RESP_OKAY;
	end else begin
		if (awReady_reg && s_axi_awvalid) begin
			awAddr_reg <= s_axi_awaddr;
			awGot_reg <= 1'b1;
			awReady_reg <= 1'b0;
		end
		if (wReady_reg && s_axi_wvalid) begin
			wData_reg <= s_axi_wdata;
			wStrb_reg <= s_axi_wstrb;
			wGot_reg <= 1'b1;
			wReady_reg <= 1'b0;
		end
		if (doWrite) begin
			bValid_reg <= 1'b1;
			bResp_reg <= wrHit ? `TCFC_RESP_OKAY : `TCFC_RESP_SLVERR;
		end
		if (bValid_reg && s_axi_bready) begin
			bValid_reg <= 1'b0;
			awGot_reg <= 1'b0;
			wGot_reg <= 1'b0;
			awReady_reg <= 1'b1;
			wReady_reg <= 1'b1;
		end
		if (arReady_reg && s_axi_arvalid) begin
			arReady_reg <= 1'b0;
			rValid_reg <= 1'b1;
			rData_reg <= readData;
			rResp_reg <= readHit ? `TCFC_RESP_OKAY : `TCFC_RESP_SLVERR;
		end
		if (rValid_reg && s_axi_rready) begin
			rValid_reg <= 1'b0;
			arReady_reg <= 1'b1;
		end
	end
end

// ----------------------------------------
// Registers and request service
// ----------------------------------------
always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		funcCode_reg <= 4'h0;
		sequenceCode_reg <= 2'h0;
		serviceRequestCode_reg <= 2'h0;
		timeBaseSelect_reg <= 3'h0;
		pinActionField_reg <= 2'h0;
		pinStateForce_reg <= 2'h3;
		matchValue_reg <= 16'h0000;
		capture_reg <= 16'h0000;
		status_reg <= 4'h0;
		mask_reg <= 4'h0;
		decoded_reg <= 10'h000;
		stepMaster_reg <= 1'b0;
	end else begin
		if (wrFunc) begin
			funcCode_reg <= (funcCode_reg & ~wMask[3:0]) | wBits[3:0];
		end
		if (wrSeq) begin
			sequenceCode_reg <= (sequenceCode_reg & ~wMask[1:0]) | wBits[1:0];
		end
		if (wrReq) begin
			serviceRequestCode_reg <= (serviceRequestCode_reg & ~wMask[1:0]) |
				wBits[1:0];
		end else if (serveNow) begin
			serviceRequestCode_reg <= 2'h0;
		end
		if (wrCtrl) begin
			if (!ctrlNew[`TCFC_CTRL_TBS_KEEP]) begin // [R18]
				timeBaseSelect_reg <= ctrlNew[7:5]; // [R18]
			end
			if (!ctrlNew[`TCFC_CTRL_PAF_KEEP]) begin // [R16]
				pinActionField_reg <= ctrlNew[3:2]; // [R16]
			end
			pinStateForce_reg <= ctrlNew[1:0];
		end
		if (wrMatch) begin
			matchValue_reg <= (matchValue_reg & ~wMask[15:0]) | wBits[15:0];
		end
		if (wrMask) begin
			mask_reg <= (mask_reg & ~wMask[3:0]) | wBits[3:0];
		end
		if (wrConfig) begin
			stepMaster_reg <= (stepMaster_reg & ~wMask[0]) | wBits[0];
		end
		status_reg <= status_next; // [R14]
		if (serveNow) begin
			decoded_reg <= {decInitPin, decFlags, decAction, decAccepted};
		end
		if (serveNow && decAccepted && decAction == `TCFC_ACT_READTB) begin
			capture_reg <= firstTimeBase_reg; // [R11]
		end else if (edgeSeen) begin
			capture_reg <= captureBase; // [R13] [R14]
		end
	end
end

// ----------------------------------------
// Time bases, pin path, interrupt
// ----------------------------------------
always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		firstTimeBase_reg <= 16'h0000;
		secondTimeBase_reg <= 16'h0000;
		div_reg <= 8'h00;
		pinSync1_reg <= 1'b0;
		pinSync2_reg <= 1'b0;
		pinPrev_reg <= 1'b0;
		matchEq_reg <= 1'b0;
		pinLevel_reg <= 1'b0;
		pinOut_reg <= 1'b0;
		pinOe_reg <= 1'b0;
		irq_reg <= 1'b0;
	end else begin
		firstTimeBase_reg <= firstTimeBase_reg + 16'h0001;
		if (div_reg == `TCFC_TB2_DIV - 8'h01) begin
			div_reg <= 8'h00;
			secondTimeBase_reg <= secondTimeBase_reg + 16'h0001;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
		pinSync1_reg <= pinIn;
		pinSync2_reg <= pinSync1_reg;
		pinPrev_reg <= pinSync2_reg;
		matchEq_reg <= matchEq;
		pinLevel_reg <= pinLevel_next;
		pinOut_reg <= pinOut_next;
		pinOe_reg <= isOutput; // [R18]
		irq_reg <= |(status_next & mask_reg);
	end
end

assign s_axi_awready = awReady_reg;
assign s_axi_wready = wReady_reg;
assign s_axi_bresp = bResp_reg;
assign s_axi_bvalid = bValid_reg;
assign s_axi_arready = arReady_reg;
assign s_axi_rdata = rData_reg;
assign s_axi_rresp = rResp_reg;
assign s_axi_rvalid = rValid_reg;
assign pinOut = pinOut_reg;
assign pinOe = pinOe_reg;
assign irq = irq_reg;

endmodule // tcfc_channel

`default_nettype wire

// ==== test/tcfc_host_model.sv ====
`default_nettype none
module tcfc_host_model (
	input wire logic clk_sys,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hung = 1'b0;
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// ----------------------------------------
	// Bus cycles, one write and one read at a time
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge clk_sys);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		r = 2'h3;
		for (n = 0; n < 64; n++) begin
			@(posedge clk_sys);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 64) hung = 1'b1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		{d, r} = '1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk_sys);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 64) hung = 1'b1;
	endtask
endmodule // tcfc_host_model
`default_nettype wire

// ==== test/tcfc_channel_sva.sv ====
`default_nettype none
module tcfc_channel_sva (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pinOut,
	input wire logic pinOe,
	input wire logic irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// ----------------------------------------
	// Write taken with both channels at once
	// ----------------------------------------
	sequence s_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr(a, c);
		s_both ##0 (s_axi_awaddr == a && c);
	endsequence
	property p_bresp_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_rdata_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_write_answer;
		s_both |=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	property p_unmapped_rd;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h28
			|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	property p_force_high;
		s_wr(8'h0C, s_axi_wdata[8:7] == 2'h1 && s_axi_wdata[1:0] == 2'h1)
			|-> ##[1:4] pinOut;
	endproperty
	property p_force_low;
		s_wr(8'h0C, s_axi_wdata[8:7] == 2'h1 && s_axi_wdata[1:0] == 2'h2)
			|-> ##[1:4] !pinOut;
	endproperty
	property p_dir_out;
		s_wr(8'h0C, s_axi_wdata[8:7] == 2'h1) |-> ##[1:4] pinOe;
	endproperty
	property p_dir_in;
		s_wr(8'h0C, s_axi_wdata[8:7] == 2'h0) |-> ##[1:4] !pinOe;
	endproperty
	property p_req_zero;
		s_wr(8'h08, s_axi_wdata[1:0] == 2'h0 && !irq) |=> !irq [*4];
	endproperty
	property p_irq_clear;
		s_wr(8'h18, s_axi_wdata[3:0] == 4'hF) |-> ##[1:3] !irq;
	endproperty
	a_bresp_hold: assert property (p_bresp_hold)
		else $error("write answer dropped early");
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read answer dropped early");
	a_read_answer: assert property (p_read_answer)
		else $error("read answer late");
	a_write_answer: assert property (p_write_answer)
		else $error("write answer not on time");
	a_unmapped_rd: assert property (p_unmapped_rd)
		else $error("unmapped read not refused");
	a_force_high: assert property (p_force_high)
		else $error("pin not forced high");
	a_force_low: assert property (p_force_low)
		else $error("pin not forced low");
	a_dir_out: assert property (p_dir_out)
		else $error("pin not made output");
	a_dir_in: assert property (p_dir_in)
		else $error("pin not made input");
	a_req_zero: assert property (p_req_zero)
		else $error("zero request acted");
	a_irq_clear: assert property (p_irq_clear)
		else $error("interrupt stuck after clear");
endmodule // tcfc_channel_sva
bind tcfc_channel tcfc_channel_sva sva_u (.clk_sys(clk_sys),
	.resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .pinOut(pinOut), .pinOe(pinOe),
	.irq(irq));
`default_nettype wire

// ==== test/tb.sv ====
`include "tcfc_defines.vh"
`default_nettype none
`define CMP(g, e) cmp(34'(g), 34'(e))
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic pinIn = 1'b0;
	wire [7:0] awaddr, araddr;
	wire [31:0] wdata, rdata;
	wire [3:0] wstrb;
	wire [1:0] bresp, rresp;
	wire awvalid, awready, wvalid, wready, bvalid, bready;
	wire arvalid, arready, rvalid, rready, pinOut, pinOe, irq;
	logic [33:0] expQ[$], maskQ[$];
	int n_errors = 0;
	int comparisons = 0;
	logic [23:0] c;
	logic [31:0] st;
	logic [1:0] r;
	// Nibbles: function, sequence, request, action, flags, init pin
	localparam logic [23:0] CASES [38] = '{24'hF13110, 24'hF33130,
		24'hF01000, 24'hF02000, 24'hE01100, 24'hE12111, 24'hE33122,
		24'hD22122, 24'hD11111, 24'hD33000, 24'hD33230, 24'hC12110,
		24'hC22120, 24'hC01000, 24'hC03000, 24'hB12300, 24'hB23410,
		24'hB32320, 24'hB01000, 24'hA11110, 24'hA22160, 24'hA03000,
		24'h912500, 24'h923610, 24'h932520, 24'h901000, 24'h812110,
		24'h833160, 24'h832000, 24'h803140, 24'h801000, 24'h701100,
		24'h712150, 24'h7331A0, 24'h632730, 24'h613110, 24'h621000,
		24'h003000};
	tcfc_channel dut_u (.clk_sys(clk_sys), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pinIn(pinIn), .pinOut(pinOut),
		.pinOe(pinOe), .irq(irq));
	tcfc_host_model hostU (.clk_sys(clk_sys), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready));
	initial forever #5 clk_sys = ~clk_sys;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic cmp(input logic [33:0] g, input logic [33:0] e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m, input logic [1:0] er = 2'h0);
		logic [31:0] d;
		logic [1:0] rr;
		expQ.push_back({er, e});
		maskQ.push_back({2'h3, m});
		hostU.rd(a, d, rr);
	endtask
	task automatic look(input logic [7:0] a, output logic [31:0] d);
		logic [1:0] rr;
		expQ.push_back(34'h0);
		maskQ.push_back(34'h0);
		hostU.rd(a, d, rr);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] rr;
		hostU.wr(a, d, rr);
		`CMP(rr, `TCFC_RESP_OKAY);
	endtask
	task automatic waitPin(input logic v);
		int n;
		for (n = 0; n < 600 && pinOut !== v; n++) @(posedge clk_sys);
		`CMP(pinOut, v);
	endtask
	// Far enough ahead that the match write lands before the count does
	task automatic arm(input logic second);
		logic [31:0] d;
		logic [15:0] m;
		look(`TCFC_OFF_TIMEBASE, d);
		m = second ? d[31:16] + 16'h20 + 16'($urandom % 16)
			: d[15:0] + 16'h40 + 16'($urandom % 64);
		wr(`TCFC_OFF_MATCH, 32'(m));
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	always @(posedge clk_sys) begin
		if (resetn && rvalid && rready) begin
			if (expQ.size() == 0) n_errors++;
			else cmp({rresp, rdata} & maskQ.pop_front(), expQ.pop_front());
		end
		if (hostU.hung === 1'b1) begin
			n_errors++;
			results();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(73));
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		chk(`TCFC_OFF_CTRL, 32'h003, '1);
		chk(`TCFC_OFF_STATUS, 32'h0, '1);
		`CMP({pinOe, irq}, 2'h0);
		chk(8'h2C, 32'h0, '1, `TCFC_RESP_SLVERR);
		hostU.wr(8'h30, 32'h1, r);
		`CMP(r, `TCFC_RESP_SLVERR);
		done("reset");
		wr(`TCFC_OFF_MASK, 32'hC);
		wr(`TCFC_OFF_FUNC, 32'hF);
		wr(`TCFC_OFF_REQ, 32'h0);
		chk(`TCFC_OFF_STATUS, 32'h0, '1);
		`CMP(irq, 1'b0);
		done("zero request");
		foreach (CASES[i]) begin
			c = CASES[i];
			if (c[23:12] == 12'hD33) wr(`TCFC_OFF_CONFIG, 32'(c[11:8] != 0));
			wr(`TCFC_OFF_FUNC, 32'(c[23:20]));
			wr(`TCFC_OFF_SEQ, 32'(c[17:16]));
			wr(`TCFC_OFF_REQ, 32'(c[13:12]));
			st = (c[11:8] != 0) ? 32'h4 : 32'h8;
			chk(`TCFC_OFF_REQ, 32'h0, '1);
			chk(`TCFC_OFF_STATUS, st, 32'hC);
			if (st == 32'h4) chk(`TCFC_OFF_DECODED,
				32'({c[1:0], c[7:4], c[10:8], 1'b1}), 32'h3FF);
			`CMP(irq, 1'b1);
			if (st == 32'h4 && c[1:0] != 2'h0) `CMP(pinOut, c[1]);
			wr(`TCFC_OFF_STATUS, 32'hF);
		end
		done("request decode");
		wr(`TCFC_OFF_MASK, 32'h0);
		wr(`TCFC_OFF_CTRL, 32'h084);
		@(posedge clk_sys) `CMP({pinOe, pinOut}, 2'h2);
		arm(1'b0);
		waitPin(1'b1);
		chk(`TCFC_OFF_STATUS, 32'h2, 32'h2);
		wr(`TCFC_OFF_CTRL, 32'h088);
		arm(1'b0);
		waitPin(1'b0);
		wr(`TCFC_OFF_CTRL, 32'h0AC);
		arm(1'b1);
		waitPin(1'b1);
		wr(`TCFC_OFF_CTRL, 32'h0AE);
		waitPin(1'b0);
		wr(`TCFC_OFF_CTRL, 32'h0AC);
		waitPin(1'b1);
		wr(`TCFC_OFF_CTRL, 32'h0AD);
		waitPin(1'b1);
		wr(`TCFC_OFF_CTRL, 32'h1F1);
		chk(`TCFC_OFF_CTRL, 32'h0AD, '1);
		done("output pin");
		wr(`TCFC_OFF_MASK, 32'h1);
		wr(`TCFC_OFF_CTRL, 32'h008);
		wr(`TCFC_OFF_STATUS, 32'hF);
		`CMP(pinOe, 1'b0);
		@(posedge clk_sys) pinIn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk(`TCFC_OFF_STATUS, 32'h0, 32'h1);
		`CMP(irq, 1'b0);
		look(`TCFC_OFF_TIMEBASE, st);
		@(posedge clk_sys) pinIn <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk(`TCFC_OFF_STATUS, 32'h1, 32'h1);
		// Edge reaches the latch five counts after the base was read
		chk(`TCFC_OFF_CAPTURE, 32'(st[15:0] + 16'h5), 32'hFFFF);
		`CMP(irq, 1'b1);
		wr(`TCFC_OFF_STATUS, 32'hF);
		`CMP(irq, 1'b0);
		done("input pin");
		results();
	end
endmodule // tb
`default_nettype wire
